// ### logic/qd_phase_decoder.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

module qd_phase_decoder (
  input  logic                clk_sys,
  input  logic                rstn,
  input  qd_pkg::qd_apb_req_s apbReq,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  logic                phaseA,
  input  logic                phaseB,
  output logic                lampOut,
  output logic                lampOe,
  output logic                phaseOwnA,
  output logic                phaseOwnB
);
  import qd_pkg::*;

  function automatic qd_step_e decodeStep(input logic [1:0] prev, input logic [1:0] cur);
    qd_step_e s;
    s = QD_STEP_DOWN;
    if (prev == cur) begin
      s = QD_STEP_NONE;
    end else if ((prev ^ cur) == 2'b11) begin
      s = QD_STEP_DOUBLE;
    end else if ({prev, cur} == 4'b0001 || {prev, cur} == 4'b0111 ||
                 {prev, cur} == 4'b1110 || {prev, cur} == 4'b1000) begin
      s = QD_STEP_UP;
    end
    return s;
  endfunction : decodeStep

  function automatic logic [INTERVAL_W-1:0] intervalUs(input logic [3:0] code);
    logic [3:0] c;
    c = (code > INTERVAL_CODE_MAX) ? INTERVAL_CODE_MAX : code;
    return INTERVAL_BASE_US << c;
  endfunction : intervalUs

  logic                       enable_r;
  qd_cfg_s                    cfg_r;
  logic [31:0]                pinLamp_r;
  logic [31:0]                pinA_r;
  logic [31:0]                pinB_r;
  logic [31:0]                shortcuts_r;
  logic [4:0]                 evt_r;
  qd_run_e                    runState_r;
  logic [TICK_CNT_W-1:0]      tickDiv_r;
  logic [INTERVAL_W-1:0]      usCnt_r;
  logic                       havePrev_r;
  logic [1:0]                 prevPair_r;
  qd_step_e                   sample_r;
  logic [1:0]                 filt_r;
  logic [1:0]                 filtFirst_r;
  logic [1:0]                 filtSame_r;
  logic signed [TOTAL_W-1:0]  total_r;
  logic signed [TOTAL_W-1:0]  totalSnap_r;
  logic [DOUBLE_W-1:0]        double_r;
  logic [DOUBLE_W-1:0]        doubleSnap_r;
  logic [REPORT_CNT_W-1:0]    reportCnt_r;
  logic                       evalPend_r;

  logic                       setupPhase;
  logic                       wrEn;
  logic                       taskStart;
  logic                       taskStop;
  logic                       running;
  logic                       usTick;
  logic                       sampleNow;
  logic                       newSample;
  logic [1:0]                 rawPair;
  logic [1:0]                 curPair;
  qd_step_e                   step;
  logic [INTERVAL_W-1:0]      periodUs;
  logic [INTERVAL_W-1:0]      leadUs;
  logic                       lampOn;
  logic                       totalOverflow;
  logic                       doubleOverflow;
  logic signed [TOTAL_W-1:0]  totalAcc;
  logic [DOUBLE_W-1:0]        doubleAcc;
  logic                       motionReport;
  logic                       doubleReport;
  logic                       snapMotion;
  logic                       snapDouble;
  logic [4:0]                 evtSet;
  logic [4:0]                 evtClr;
  logic [31:0]                readData;
  logic                       mapped;

  // apb: setup registers read data, access phase completes with pready high
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite & pready;

  function automatic logic wrTask(input logic en, input qd_apb_req_s r, input logic [11:0] ofs);
    return en & (r.paddr == ofs) & r.pwdata[0];
  endfunction : wrTask

  assign taskStart = wrTask(wrEn, apbReq, OFS_TASK_START);
  assign taskStop = wrTask(wrEn, apbReq, OFS_TASK_STOP);
  assign running = (runState_r == QD_RUN);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      runState_r <= QD_IDLE;
    end else begin
      case (runState_r)
        QD_IDLE: runState_r <= (taskStart & enable_r) ? QD_RUN : QD_IDLE;
        QD_RUN:  runState_r <= (taskStop | ~enable_r) ? QD_IDLE : QD_RUN;
        default: runState_r <= QD_IDLE;
      endcase
    end
  end

  // 1 us tick and position within the sample interval
  assign usTick = running & (tickDiv_r == TICK_CNT_W'(FILTER_TICK_CYCLES - 1));
  assign periodUs = intervalUs(cfg_r.sampleInterval);
  assign sampleNow = usTick & (usCnt_r == periodUs - 18'h00001);

  always_ff @(posedge clk_sys) begin
    if (!rstn || !running) begin
      tickDiv_r <= '0;
      usCnt_r <= '0;
    end else begin
      tickDiv_r <= usTick ? '0 : tickDiv_r + 1'b1;
      if (sampleNow) begin
        usCnt_r <= '0;
      end else if (usTick) begin
        usCnt_r <= usCnt_r + 18'h00001;
      end
    end
  end

  // a disconnected phase reads as low
  assign rawPair = {phaseA & ~pinA_r[PIN_DISCONNECT_BIT], phaseB & ~pinB_r[PIN_DISCONNECT_BIT]};

  // debounce: while running, the filter output moves only at interval end, so the decoder
  // sees the level one full interval later than the raw path
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      filt_r <= '0;
      filtFirst_r <= '0;
      filtSame_r <= '0;
    end else if (!running) begin
      filt_r <= rawPair;
      filtSame_r <= '0;
    end else if (usTick) begin
      for (int i = 0; i < 2; i++) begin
        if (usCnt_r == '0) begin
          filtFirst_r[i] <= rawPair[i];
          filtSame_r[i] <= 1'b1;
        end else begin
          filtSame_r[i] <= filtSame_r[i] & (rawPair[i] == filtFirst_r[i]);
        end
        if (sampleNow && filtSame_r[i] && rawPair[i] == filtFirst_r[i]) begin
          filt_r[i] <= filtFirst_r[i];
        end
      end
    end
  end

  assign curPair = cfg_r.debounceOn ? filt_r : rawPair;
  assign step = havePrev_r ? decodeStep(prevPair_r, curPair) : QD_STEP_NONE;
  assign newSample = sampleNow & havePrev_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn || !running) begin
      havePrev_r <= 1'b0;
      prevPair_r <= '0;
    end else if (sampleNow) begin
      havePrev_r <= 1'b1;
      prevPair_r <= curPair;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sample_r <= QD_STEP_NONE;
    end else if (newSample) begin
      sample_r <= step;
    end
  end

  // accumulation with saturation check: signed for the total, unsigned for the double count
  assign totalOverflow = newSample &
                         ((step == QD_STEP_UP && total_r == {1'b0, {(TOTAL_W-1){1'b1}}}) ||
                          (step == QD_STEP_DOWN && total_r == {1'b1, {(TOTAL_W-1){1'b0}}}));
  assign doubleOverflow = newSample & (step == QD_STEP_DOUBLE) & (&double_r);

  always_comb begin
    totalAcc = total_r;
    doubleAcc = double_r;
    if (newSample && !totalOverflow && step == QD_STEP_UP) begin
      totalAcc = total_r + 32'sh00000001;
    end else if (newSample && !totalOverflow && step == QD_STEP_DOWN) begin
      totalAcc = total_r - 32'sh00000001;
    end
    if (newSample && !doubleOverflow && step == QD_STEP_DOUBLE) begin
      doubleAcc = double_r + 4'h1;
    end
  end

  // report evaluation one cycle after the closing sample, on settled counters
  always_ff @(posedge clk_sys) begin
    if (!rstn || !running) begin
      reportCnt_r <= '0;
      evalPend_r <= 1'b0;
    end else begin
      evalPend_r <= 1'b0;
      if (newSample) begin
        if (reportCnt_r >= {1'b0, cfg_r.reportInterval}) begin
          reportCnt_r <= '0;
          evalPend_r <= 1'b1;
        end else begin
          reportCnt_r <= reportCnt_r + 5'h01;
        end
      end
    end
  end

  assign motionReport = evalPend_r & (total_r != '0);
  assign doubleReport = evalPend_r & (double_r != '0);

  assign snapMotion = wrTask(wrEn, apbReq, OFS_SNAP_CLEAR_BOTH) |
                      wrTask(wrEn, apbReq, OFS_SNAP_CLEAR_MOTION);
  assign snapDouble = wrTask(wrEn, apbReq, OFS_SNAP_CLEAR_BOTH) |
                      wrTask(wrEn, apbReq, OFS_SNAP_CLEAR_DOUBLE) |
                      (doubleReport & shortcuts_r[SHORT_DOUBLE_EVENT_TO_SNAP_LINK]);

  // a step landing in the snapshot cycle goes into the snapshot, never lost
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      total_r <= '0;
      totalSnap_r <= '0;
    end else if (snapMotion) begin
      totalSnap_r <= totalAcc;
      total_r <= '0;
    end else begin
      total_r <= totalAcc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      double_r <= '0;
      doubleSnap_r <= '0;
    end else if (snapDouble) begin
      doubleSnap_r <= doubleAcc;
      double_r <= '0;
    end else begin
      double_r <= doubleAcc;
    end
  end

  // events: hardware set wins over a software clear in the same cycle
  always_comb begin
    evtSet = '0;
    evtSet[EVT_SAMPLE_READY] = newSample;
    evtSet[EVT_MOTION_REPORT] = motionReport;
    evtSet[EVT_TOTAL_OVERFLOW] = totalOverflow | doubleOverflow;
    evtSet[EVT_DOUBLE_REPORT] = doubleReport;
    evtSet[EVT_STOPPED] = taskStop | (running & ~enable_r);
    evtClr = '0;
    if (wrEn && !apbReq.pwdata[0]) begin
      evtClr[EVT_SAMPLE_READY] = (apbReq.paddr == OFS_EVT_SAMPLE_READY);
      evtClr[EVT_MOTION_REPORT] = (apbReq.paddr == OFS_EVT_MOTION_REPORT);
      evtClr[EVT_TOTAL_OVERFLOW] = (apbReq.paddr == OFS_EVT_TOTAL_OVERFLOW);
      evtClr[EVT_DOUBLE_REPORT] = (apbReq.paddr == OFS_EVT_DOUBLE_REPORT);
      evtClr[EVT_STOPPED] = (apbReq.paddr == OFS_EVT_STOPPED);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      evt_r <= '0;
    end else begin
      evt_r <= evtSet | (evt_r & ~evtClr);
    end
  end

  // configuration registers; changing them while running is left to software
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      enable_r <= 1'b0;
      cfg_r <= '{debounceOn: 1'b0, lampPolarity: 1'b0, sampleInterval: SAMPLE_INTERVAL_RESET,
                 reportInterval: REPORT_INTERVAL_RESET, lampLeadTime: LAMP_LEAD_TIME_RESET};
      pinLamp_r <= PIN_SEL_RESET;
      pinA_r <= PIN_SEL_RESET;
      pinB_r <= PIN_SEL_RESET;
      shortcuts_r <= '0;
    end else if (wrEn) begin
      case (apbReq.paddr)
        OFS_ENABLE:          enable_r <= apbReq.pwdata[0];
        OFS_LAMP_POLARITY:   cfg_r.lampPolarity <= apbReq.pwdata[0];
        OFS_SAMPLE_INTERVAL: cfg_r.sampleInterval <= apbReq.pwdata[3:0];
        OFS_REPORT_INTERVAL: cfg_r.reportInterval <= apbReq.pwdata[3:0];
        OFS_DEBOUNCE_ON:     cfg_r.debounceOn <= apbReq.pwdata[0];
        OFS_LAMP_LEAD_TIME:  cfg_r.lampLeadTime <= apbReq.pwdata[8:0];
        OFS_PIN_LAMP:        pinLamp_r <= apbReq.pwdata;
        OFS_PIN_A:           pinA_r <= apbReq.pwdata;
        OFS_PIN_B:           pinB_r <= apbReq.pwdata;
        OFS_SHORTCUTS:       shortcuts_r <= {27'h0000000, apbReq.pwdata[4], 4'h0};
        default:             enable_r <= enable_r;
      endcase
    end
  end

  // lamp window: the last lead-time microseconds of each interval, or the whole run while debounce is on
  assign leadUs = {9'h000, cfg_r.lampLeadTime};
  assign lampOn = running & (cfg_r.debounceOn | (leadUs >= periodUs) | (usCnt_r >= periodUs - leadUs));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lampOut <= 1'b0;
      lampOe <= 1'b0;
      phaseOwnA <= 1'b0;
      phaseOwnB <= 1'b0;
    end else begin
      lampOe <= enable_r & ~pinLamp_r[PIN_DISCONNECT_BIT];
      phaseOwnA <= enable_r & ~pinA_r[PIN_DISCONNECT_BIT];
      phaseOwnB <= enable_r & ~pinB_r[PIN_DISCONNECT_BIT];
      lampOut <= (enable_r & ~pinLamp_r[PIN_DISCONNECT_BIT]) & (lampOn ? cfg_r.lampPolarity
                                                                       : ~cfg_r.lampPolarity);
    end
  end

  always_comb begin
    readData = '0;
    mapped = 1'b1;
    case (apbReq.paddr)
      OFS_TASK_START, OFS_TASK_STOP, OFS_SNAP_CLEAR_BOTH,
      OFS_SNAP_CLEAR_MOTION, OFS_SNAP_CLEAR_DOUBLE: readData = '0;
      OFS_EVT_SAMPLE_READY:   readData[0] = evt_r[EVT_SAMPLE_READY];
      OFS_EVT_MOTION_REPORT:  readData[0] = evt_r[EVT_MOTION_REPORT];
      OFS_EVT_TOTAL_OVERFLOW: readData[0] = evt_r[EVT_TOTAL_OVERFLOW];
      OFS_EVT_DOUBLE_REPORT:  readData[0] = evt_r[EVT_DOUBLE_REPORT];
      OFS_EVT_STOPPED:        readData[0] = evt_r[EVT_STOPPED];
      OFS_SHORTCUTS:          readData = shortcuts_r;
      OFS_ENABLE:             readData[0] = enable_r;
      OFS_LAMP_POLARITY:      readData[0] = cfg_r.lampPolarity;
      OFS_SAMPLE_INTERVAL:    readData[3:0] = cfg_r.sampleInterval;
      OFS_REPORT_INTERVAL:    readData[3:0] = cfg_r.reportInterval;
      OFS_DEBOUNCE_ON:        readData[0] = cfg_r.debounceOn;
      OFS_LAMP_LEAD_TIME:     readData[8:0] = cfg_r.lampLeadTime;
      OFS_PIN_LAMP:           readData = pinLamp_r;
      OFS_PIN_A:              readData = pinA_r;
      OFS_PIN_B:              readData = pinB_r;
      OFS_MOTION_TOTAL:       readData = total_r;
      OFS_MOTION_SNAPSHOT:    readData = totalSnap_r;
      OFS_DOUBLE_COUNT:       readData[DOUBLE_W-1:0] = double_r;
      OFS_DOUBLE_SNAPSHOT:    readData[DOUBLE_W-1:0] = doubleSnap_r;
      OFS_SAMPLE: begin
        case (sample_r)
          QD_STEP_UP:     readData = 32'h00000001;
          QD_STEP_DOWN:   readData = 32'hFFFFFFFF;
          QD_STEP_DOUBLE: readData = 32'h00000002;
          default:        readData = 32'h00000000;
        endcase
      end
      default:                mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      if (setupPhase) begin
        prdata <= apbReq.pwrite ? 32'h00000000 : readData;
      end
    end
  end

endmodule : qd_phase_decoder

// ### inc/qd_pkg.sv
package qd_pkg;

  // clock and filter tick
  localparam int CLK_PERIOD_NS = 5;
  localparam int FILTER_TICK_NS = 1000;
  localparam int FILTER_TICK_CYCLES = (FILTER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 8;

  // sample interval: base interval doubled per code step, code capped
  localparam int INTERVAL_W = 18;
  localparam logic [INTERVAL_W-1:0] INTERVAL_BASE_US = 18'h00080;
  localparam logic [3:0] INTERVAL_CODE_MAX = 4'hA;

  // counter widths
  localparam int TOTAL_W = 32;
  localparam int DOUBLE_W = 4;
  localparam int REPORT_CNT_W = 5;

  // register byte offsets
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP = 12'h004;
  localparam logic [11:0] OFS_SNAP_CLEAR_BOTH = 12'h008;
  localparam logic [11:0] OFS_SNAP_CLEAR_MOTION = 12'h00C;
  localparam logic [11:0] OFS_SNAP_CLEAR_DOUBLE = 12'h010;
  localparam logic [11:0] OFS_EVT_SAMPLE_READY = 12'h100;
  localparam logic [11:0] OFS_EVT_MOTION_REPORT = 12'h104;
  localparam logic [11:0] OFS_EVT_TOTAL_OVERFLOW = 12'h108;
  localparam logic [11:0] OFS_EVT_DOUBLE_REPORT = 12'h10C;
  localparam logic [11:0] OFS_EVT_STOPPED = 12'h110;
  localparam logic [11:0] OFS_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_LAMP_POLARITY = 12'h504;
  localparam logic [11:0] OFS_SAMPLE_INTERVAL = 12'h508;
  localparam logic [11:0] OFS_SAMPLE = 12'h50C;
  localparam logic [11:0] OFS_REPORT_INTERVAL = 12'h510;
  localparam logic [11:0] OFS_MOTION_TOTAL = 12'h514;
  localparam logic [11:0] OFS_MOTION_SNAPSHOT = 12'h518;
  localparam logic [11:0] OFS_PIN_LAMP = 12'h51C;
  localparam logic [11:0] OFS_PIN_A = 12'h520;
  localparam logic [11:0] OFS_PIN_B = 12'h524;
  localparam logic [11:0] OFS_DEBOUNCE_ON = 12'h528;
  localparam logic [11:0] OFS_LAMP_LEAD_TIME = 12'h540;
  localparam logic [11:0] OFS_DOUBLE_COUNT = 12'h544;
  localparam logic [11:0] OFS_DOUBLE_SNAPSHOT = 12'h548;

  // field positions
  localparam int EVT_SAMPLE_READY = 0;
  localparam int EVT_MOTION_REPORT = 1;
  localparam int EVT_TOTAL_OVERFLOW = 2;
  localparam int EVT_DOUBLE_REPORT = 3;
  localparam int EVT_STOPPED = 4;
  localparam int SHORT_DOUBLE_EVENT_TO_SNAP_LINK = 4;
  localparam int PIN_DISCONNECT_BIT = 31;

  // reset values
  localparam logic [31:0] PIN_SEL_RESET = 32'hFFFFFFFF;
  localparam logic [3:0] SAMPLE_INTERVAL_RESET = 4'h0;
  localparam logic [3:0] REPORT_INTERVAL_RESET = 4'h0;
  localparam logic [8:0] LAMP_LEAD_TIME_RESET = 9'h010;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } qd_apb_req_s;

  typedef struct packed {
    logic       debounceOn;
    logic       lampPolarity;
    logic [3:0] sampleInterval;
    logic [3:0] reportInterval;
    logic [8:0] lampLeadTime;
  } qd_cfg_s;

  typedef enum logic [1:0] {
    QD_STEP_NONE   = 2'b00,
    QD_STEP_UP     = 2'b01,
    QD_STEP_DOWN   = 2'b10,
    QD_STEP_DOUBLE = 2'b11
  } qd_step_e;

  typedef enum logic {
    QD_IDLE = 1'b0,
    QD_RUN  = 1'b1
  } qd_run_e;

endpackage : qd_pkg

// ### bench/qd_phase_decoder_properties.sv
`timescale 1ns/100ps
module qd_phase_decoder_properties (
  input logic                clk_sys,
  input logic                rstn,
  input qd_pkg::qd_apb_req_s apbReq,
  input logic [31:0]         prdata,
  input logic                pready,
  input logic                pslverr,
  input logic                phaseA,
  input logic                phaseB,
  input logic                lampOut,
  input logic                lampOe,
  input logic                phaseOwnA,
  input logic                phaseOwnB
);
  import qd_pkg::*;
  logic wrLand;
  assign wrLand = pready && apbReq.pwrite;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  // a lamp edge while the pin stays owned starts a long on or off phase
  sequence s_lamp_toggle;
    lampOe && $past(lampOe) && $changed(lampOut);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> apbReq.psel && apbReq.penable)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pslverr && !apbReq.pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_lamp_unowned_low: assert property (!lampOe |-> !lampOut)
    else $error("lamp driven while not owned");
  a_lamp_phase_holds: assert property (s_lamp_toggle |=> (!lampOe || $stable(lampOut))[*8])
    else $error("lamp glitch after edge");
  a_owner_after_write: assert property ($rose(phaseOwnA) |-> $past(wrLand) || $past(wrLand, 2))
    else $error("pin claimed without a write");
  a_quiet_reset: assert property (disable iff (1'b0) !rstn |=> !pready && !lampOe && !phaseOwnA && !phaseOwnB)
    else $error("outputs active after reset");
endmodule : qd_phase_decoder_properties

bind qd_phase_decoder qd_phase_decoder_properties u_props (
  .clk_sys(clk_sys), .rstn(rstn), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phaseA(phaseA), .phaseB(phaseB), .lampOut(lampOut), .lampOe(lampOe), .phaseOwnA(phaseOwnA), .phaseOwnB(phaseOwnB)
);

// ### bench/qd_encoder_model.sv
`timescale 1ns/100ps
module qd_encoder_model (
  input  logic       clk_sys,
  input  logic       rstn,
  input  logic [1:0] startPos,
  input  logic       moveGo,
  input  logic [1:0] moveBy,
  output logic       phaseA,
  output logic       phaseB
);
  logic [1:0] pos_r;
  // moveBy 1 is forward, 3 is back, 2 skips a step so both phases flip at once
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pos_r <= startPos;
    end else if (moveGo) begin
      pos_r <= pos_r + moveBy;
    end
  end
  // gray order: only one phase changes per single step
  assign phaseA = pos_r[1];
  assign phaseB = pos_r[1] ^ pos_r[0];
endmodule : qd_encoder_model

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
  import qd_pkg::*;
  logic        clk_sys;
  logic        rstn;
  qd_apb_req_s apbReq;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        phaseA;
  logic        phaseB;
  logic        lampOut;
  logic        lampOe;
  logic        phaseOwnA;
  logic        phaseOwnB;
  logic        moveGo;
  logic [1:0]  moveBy;
  logic [1:0]  startPos;
  logic [1:0]  dirCode;
  logic        pol;
  logic [31:0] rd;
  logic        er;
  int          errTotal;
  int          checkCount;

  qd_phase_decoder dut (.clk_sys(clk_sys), .rstn(rstn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .lampOut(lampOut), .lampOe(lampOe),
    .phaseOwnA(phaseOwnA), .phaseOwnB(phaseOwnB));
  qd_encoder_model enc (.clk_sys(clk_sys), .rstn(rstn), .startPos(startPos), .moveGo(moveGo), .moveBy(moveBy),
    .phaseA(phaseA), .phaseB(phaseB));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one transfer; the request stands until pready is seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    chk("pready", 32'h00000001, {31'h0, pready});
    apbReq <= '0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h00000000);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic move(input logic [1:0] by);
    moveBy <= by;
    moveGo <= 1'b1;
    @(posedge clk_sys);
    moveGo <= 1'b0;
    @(posedge clk_sys);
  endtask : move

  function automatic logic [31:0] step_val(input logic [1:0] by);
    return (by == 2'b01) ? 32'h00000001 : 32'hFFFFFFFF;
  endfunction : step_val

  task automatic pins(input logic [1:0] own, input logic oe);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("own", {30'h0, own}, {30'h0, phaseOwnA, phaseOwnB});
    chk("lampOe", {31'h0, oe}, {31'h0, lampOe});
    @(posedge clk_sys);
  endtask : pins

  initial begin
    apbReq = '0;
    rstn = 1'b0;
    moveGo = 1'b0;
    moveBy = 2'b00;
    errTotal = 0;
    checkCount = 0;
    void'($urandom(82));
    startPos = 2'($urandom());
    pol = 1'($urandom());
    dirCode = $urandom() & 1 ? 2'b01 : 2'b11;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdchk("pin_a_reset", OFS_PIN_A, PIN_SEL_RESET);
    rdchk("lead_reset", OFS_LAMP_LEAD_TIME, {23'h0, LAMP_LEAD_TIME_RESET});
    apb(12'h7F0, 1'b0, 32'h0);
    chk("unmapped", 32'h00000001, {31'h0, er});
    apb(OFS_LAMP_POLARITY, 1'b1, {31'h0, pol});
    apb(OFS_SHORTCUTS, 1'b1, 32'h1 << SHORT_DOUBLE_EVENT_TO_SNAP_LINK);
    apb(OFS_PIN_A, 1'b1, 32'h00000000);
    apb(OFS_PIN_B, 1'b1, 32'h00000001);
    apb(OFS_ENABLE, 1'b1, 32'h00000001);
    pins(2'b11, 1'b0);
    apb(OFS_PIN_LAMP, 1'b1, 32'h00000002);
    pins(2'b11, 1'b1);
    apb(OFS_TASK_START, 1'b1, 32'h00000001);
    repeat (23000) @(posedge clk_sys);
    chk("lamp_lead", {31'h0, pol}, {31'h0, lampOut});
    repeat (3000) @(posedge clk_sys);
    chk("lamp_after", {31'h0, ~pol}, {31'h0, lampOut});
    rdchk("seed_ready", OFS_EVT_SAMPLE_READY, 32'h0);
    rdchk("seed_total", OFS_MOTION_TOTAL, 32'h0);
    move(dirCode);
    repeat (25600) @(posedge clk_sys);
    rdchk("step_ready", OFS_EVT_SAMPLE_READY, 32'h1);
    rdchk("step_total", OFS_MOTION_TOTAL, step_val(dirCode));
    rdchk("step_double", OFS_DOUBLE_COUNT, 32'h0);
    rdchk("motion_report", OFS_EVT_MOTION_REPORT, 32'h1);
    rdchk("no_dbl_report", OFS_EVT_DOUBLE_REPORT, 32'h0);
    move(2'b10);
    repeat (25600) @(posedge clk_sys);
    rdchk("dbl_sample", OFS_SAMPLE, 32'h2);
    rdchk("dbl_total", OFS_MOTION_TOTAL, step_val(dirCode));
    rdchk("dbl_report", OFS_EVT_DOUBLE_REPORT, 32'h1);
    rdchk("link_snap", OFS_DOUBLE_SNAPSHOT, 32'h1);
    rdchk("link_clear", OFS_DOUBLE_COUNT, 32'h0);
    apb(OFS_SNAP_CLEAR_MOTION, 1'b1, 32'h00000001);
    rdchk("motion_snap", OFS_MOTION_SNAPSHOT, step_val(dirCode));
    rdchk("motion_clear", OFS_MOTION_TOTAL, 32'h0);
    rdchk("dbl_snap_kept", OFS_DOUBLE_SNAPSHOT, 32'h1);
    apb(OFS_SNAP_CLEAR_DOUBLE, 1'b1, 32'h00000001);
    rdchk("dbl_only_snap", OFS_DOUBLE_SNAPSHOT, 32'h0);
    rdchk("dbl_only_motion", OFS_MOTION_SNAPSHOT, step_val(dirCode));
    apb(OFS_SNAP_CLEAR_BOTH, 1'b1, 32'h00000001);
    rdchk("both_motion", OFS_MOTION_SNAPSHOT, 32'h0);
    rdchk("both_double", OFS_DOUBLE_SNAPSHOT, 32'h0);
    apb(OFS_TASK_STOP, 1'b1, 32'h00000001);
    rdchk("stopped", OFS_EVT_STOPPED, 32'h1);
    // with debounce the lamp must be on at once, long before the lead window opens
    apb(OFS_DEBOUNCE_ON, 1'b1, 32'h00000001);
    apb(OFS_TASK_START, 1'b1, 32'h00000001);
    repeat (16) @(posedge clk_sys);
    chk("lamp_debounce", {31'h0, pol}, {31'h0, lampOut});
    apb(OFS_TASK_STOP, 1'b1, 32'h00000001);
    apb(OFS_ENABLE, 1'b1, 32'h00000000);
    pins(2'b00, 1'b0);
    close_out();
  end

  // the sequence above needs about 77400 cycles
  initial begin
    repeat (95000) @(posedge clk_sys);
    errTotal++;
    close_out();
  end
endmodule : tb
